// File: logic/wpl_pkg.sv
`default_nettype none
package wpl_pkg;
	// ==================================================
	// Label octet
	localparam logic [7:0] WPL_LABEL_RST    = 8'h1A;
	localparam logic [7:0] WPL_LABEL_UNEQ   = 8'h00;
	localparam int         WPL_LABEL_FRAMES = 5;
	// ==================================================
	// Status octet layout, transmission bit 1 is the MSB
	localparam int WPL_REI_MSB  = 7;
	localparam int WPL_REI_LSB  = 4;
	localparam int WPL_CODE_MSB = 3;
	localparam int WPL_CODE_LSB = 1;
	localparam int WPL_RDI_BIT  = 3;
	localparam logic [3:0] WPL_REI_MAX = 4'h8;
	localparam int         WPL_DEFECT_FRAMES = 10;
	// ==================================================
	// Defect codes carried in bits 5 to 7
	localparam logic [2:0] WPL_CODE_CLEAR1  = 3'h0;
	localparam logic [2:0] WPL_CODE_RDI1    = 3'h4;
	localparam logic [2:0] WPL_CODE_NONE    = 3'h1;
	localparam logic [2:0] WPL_CODE_PAYLOAD = 3'h2;
	localparam logic [2:0] WPL_CODE_SERVER  = 3'h5;
	localparam logic [2:0] WPL_CODE_CONN    = 3'h6;
	// ==================================================
	// Event indices of the pending vector
	localparam int WPL_EV_UNEQ     = 0;
	localparam int WPL_EV_MISMATCH = 1;
	localparam int WPL_EV_WRAP_NZ  = 2;
	localparam int WPL_EV_TICK_NZ  = 3;
	localparam int WPL_EV_FAR_DEF  = 4;
	localparam int WPL_EV_FAR_PAY  = 5;
	localparam int WPL_EV_FAR_SRV  = 6;
	localparam int WPL_EV_FAR_UNEQ = 7;
	localparam int WPL_NUM_EV      = 8;
	localparam int WPL_NUM_MASK    = 7;
	// ==================================================
	// Configuration and status carriers
	typedef struct packed {
		logic [7:0]              tx_signal_label;
		logic [7:0]              expected_signal_label;
		logic                    remote_err_block_mode;
		logic                    rx_enhanced_defect_sel;
		logic                    tx_enhanced_defect_sel;
		logic [WPL_NUM_MASK-1:0] mask_a;
		logic [WPL_NUM_MASK-1:0] mask_b;
	} wpl_cfg_t;

	localparam wpl_cfg_t WPL_CFG_RST = '{
		tx_signal_label:        WPL_LABEL_RST,
		expected_signal_label:  WPL_LABEL_RST,
		remote_err_block_mode:  1'b0,
		rx_enhanced_defect_sel: 1'b1,
		tx_enhanced_defect_sel: 1'b1,
		mask_a:                 7'h00,
		mask_b:                 7'h00
	};

	typedef struct packed {
		logic [7:0]            accepted_label;
		logic                  unequipped_live;
		logic                  label_mismatch_latched;
		logic                  remote_err_nonzero_live;
		logic                  tick_counter_nonzero_live;
		logic                  far_defect_live;
		logic                  far_payload_defect_latched;
		logic                  far_server_defect_latched;
		logic                  far_unequipped_live;
		logic [WPL_NUM_EV-1:0] pending;
	} wpl_stat_t;

	localparam wpl_stat_t WPL_STAT_RST = '0;
endpackage : wpl_pkg
`default_nettype wire

// File: logic/wpl_persist.sv
`timescale 1ns/1ps
`default_nettype none
module wpl_persist import wpl_pkg::*; #(
	parameter int W = 8,
	parameter int N = 5
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         reset,
	input  wire logic         clk_en,
	// Per-frame sample
	input  wire logic         strobe,
	input  wire logic [W-1:0] value,
	// Accepted value
	output logic      [W-1:0] acc_value,
	output logic              acc_valid
);
	localparam int CW = $clog2(N + 1);
	localparam logic [CW-1:0] RUN_FULL = CW'(N);

	logic [W-1:0]  cand_r, cand_nxt, acc_r, acc_nxt;
	logic [CW-1:0] run_r, run_nxt;
	logic          accv_r, accv_nxt;

	always_comb begin
		cand_nxt = cand_r;
		run_nxt  = run_r;
		acc_nxt  = acc_r;
		accv_nxt = accv_r;
		if (strobe) begin
			if (value == cand_r && run_r != '0) begin
				run_nxt = (run_r == RUN_FULL) ? run_r : run_r + 1'b1;
			end else begin
				cand_nxt = value;
				run_nxt  = CW'(1);
			end
			if (run_nxt == RUN_FULL) begin
				acc_nxt  = cand_nxt;
				accv_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			cand_r <= '0;
			run_r  <= '0;
			acc_r  <= '0;
			accv_r <= 1'b0;
		end else if (clk_en) begin
			cand_r <= cand_nxt;
			run_r  <= run_nxt;
			acc_r  <= acc_nxt;
			accv_r <= accv_nxt;
		end
	end

	assign acc_value = acc_r;
	assign acc_valid = accv_r;

	// Accepted value moves only after N matching frames
	property p_persist_accept;
		@(posedge clock) disable iff (reset)
		(acc_r != $past(acc_r)) |-> (run_r == RUN_FULL && $past(strobe));
	endproperty
	a_persist_accept: assert property (p_persist_accept) else $error("accept without run");
endmodule : wpl_persist
`default_nettype wire

// File: logic/wpl_err_counters.sv
`timescale 1ns/1ps
`default_nettype none
module wpl_err_counters import wpl_pkg::*; (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        clk_en,
	// Received remote error count per frame
	input  wire logic        frame_strobe,
	input  wire logic [3:0]  rei,
	input  wire logic        block_mode,
	input  wire logic        tick,
	// Counters
	output logic      [15:0] wrap_count,
	output logic      [31:0] tick_count,
	output logic      [31:0] tick_snapshot
);
	logic [15:0] wrap_r, wrap_nxt;
	logic [31:0] tick_r, tick_nxt, snap_r, snap_nxt;
	logic [31:0] inc;
	logic [32:0] sum;

	always_comb begin
		inc      = '0;
		wrap_nxt = wrap_r;
		snap_nxt = snap_r;
		if (frame_strobe) begin
			inc = block_mode ? 32'(rei != 4'h0) : 32'(rei);
			if (rei != 4'h0) begin
				wrap_nxt = wrap_r + 16'h0001;
			end
		end
		sum = {1'b0, tick_r} + {1'b0, inc};
		// Saturate rather than wrap
		tick_nxt = sum[32] ? 32'hFFFFFFFF : sum[31:0];
		if (tick) begin
			// Error of the tick frame starts the new period
			snap_nxt = tick_r;
			tick_nxt = inc;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wrap_r <= '0;
			tick_r <= '0;
			snap_r <= '0;
		end else if (clk_en) begin
			wrap_r <= wrap_nxt;
			tick_r <= tick_nxt;
			snap_r <= snap_nxt;
		end
	end

	assign wrap_count    = wrap_r;
	assign tick_count    = tick_r;
	assign tick_snapshot = snap_r;

	property p_wrap_step;
		@(posedge clock) disable iff (reset)
		(clk_en && frame_strobe && rei != 4'h0) |=> (wrap_r == $past(wrap_r) + 16'h0001);
	endproperty
	a_wrap_step: assert property (p_wrap_step) else $error("wrap counter step wrong");

	property p_tick_clear;
		@(posedge clock) disable iff (reset)
		(clk_en && tick && !frame_strobe) |=> (tick_r == 32'h0 && snap_r == $past(tick_r));
	endproperty
	a_tick_clear: assert property (p_tick_clear) else $error("tick did not latch and clear");

	property p_block_inc;
		@(posedge clock) disable iff (reset)
		(clk_en && block_mode && !tick && tick_r < 32'hFFFF0000) |=>
			(tick_r - $past(tick_r) <= 32'h1);
	endproperty
	a_block_inc: assert property (p_block_inc) else $error("block mode step above one");
endmodule : wpl_err_counters
`default_nettype wire

// File: logic/wpl_path_monitor.sv
// Notes on behaviour
// - Transmit programmable label each frame, reset 1A.
// - Accept label after five equal frames.
// - Accepted label zero flags unequipped, pending plus live.
// - Nonzero differing label latches mismatch plus pending.
// - Every pending flag masked onto outputs A, B.
// - Mismatch sends payload defect code, not defect.
// - Status bits 1-4 carry near B3 count.
// - Sixteen-bit remote error counter wraps around.
// - Wrap counter clears on reset; nonzero pending.
// - Saturating 32-bit counter latched, cleared by tick.
// - Tick counter nonzero gives pending and live.
// - Block mode adds at most one per frame.
// - One-bit or enhanced format per direction.
// - One-bit: bit 5 defect, 6-7 zero.
// - Enhanced: bits 5-7 code, bit 8 ignored.
// - One-bit receive: codes 100/111 defect, 000/011 none.
// - Enhanced codes with priority 101,110,010,001.
// - One-bit defect needs ten frames on, off.
// - Enhanced defect needs ten frames persistence.
// - Code 010 latches payload status plus pending.
// - Code 101 latches server status plus pending.
// - Code 110 gives pending, live, defect masks.
// - No count sends zero; surplus count discarded.
`timescale 1ns/1ps
`default_nettype none
module wpl_path_monitor import wpl_pkg::*; (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        clk_en,
	// Configuration
	input  wire logic        cfg_load,
	input  wire wpl_cfg_t    cfg_in,
	input  wire logic        pending_read,
	input  wire logic        stats_snapshot_tick,
	// Near-end conditions
	input  wire logic        near_server_defect,
	input  wire logic        near_payload_defect,
	input  wire logic        near_connectivity_force,
	input  wire logic        near_b3_valid,
	input  wire logic [3:0]  near_b3_count,
	// Transmit frame
	input  wire logic        tx_frame_start,
	output logic             tx_octets_valid,
	output logic      [7:0]  tx_label_octet,
	output logic      [7:0]  tx_status_octet,
	// Receive frame
	input  wire logic        rx_frame_valid,
	input  wire logic [7:0]  rx_label_octet,
	input  wire logic [7:0]  rx_status_octet,
	// Status and counters
	output wpl_cfg_t         cfg_out,
	output wpl_stat_t        status,
	output logic      [15:0] remote_err_wrap_counter,
	output logic      [31:0] remote_err_tick_counter,
	output logic             irq_out_a,
	output logic             irq_out_b
);
	// ==================================================
	// Configuration
	wpl_cfg_t cfg_r, cfg_nxt;

	always_comb begin
		cfg_nxt = cfg_load ? cfg_in : cfg_r;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			cfg_r <= WPL_CFG_RST;
		end else if (clk_en) begin
			cfg_r <= cfg_nxt;
		end
	end

	assign cfg_out = cfg_r;

	// ==================================================
	// Receive label and status filters
	logic [7:0] acc_label;
	logic       acc_label_v;
	logic [2:0] rx_code_raw, rx_code_map, acc_code;
	logic       acc_code_v;
	logic [3:0] rx_rei;

	wpl_persist #(
		.W (8),
		.N (WPL_LABEL_FRAMES)
	) u_label_filter (
		.clock     (clock),
		.reset     (reset),
		.clk_en    (clk_en),
		.strobe    (rx_frame_valid),
		.value     (rx_label_octet),
		.acc_value (acc_label),
		.acc_valid (acc_label_v)
	);

	always_comb begin
		rx_code_raw = rx_status_octet[WPL_CODE_MSB:WPL_CODE_LSB];
		// Bit 8 never reaches the decoders
		if (!cfg_r.rx_enhanced_defect_sel) begin
			rx_code_map = rx_status_octet[WPL_RDI_BIT] ? WPL_CODE_RDI1 : WPL_CODE_CLEAR1;
		end else begin
			unique case (rx_code_raw)
				WPL_CODE_PAYLOAD, WPL_CODE_SERVER, WPL_CODE_CONN: rx_code_map = rx_code_raw;
				default: rx_code_map = WPL_CODE_NONE;
			endcase
		end
		// Counts above eight are not legal and add nothing
		rx_rei = rx_status_octet[WPL_REI_MSB:WPL_REI_LSB];
		if (rx_rei > WPL_REI_MAX) begin
			rx_rei = 4'h0;
		end
	end

	wpl_persist #(
		.W (3),
		.N (WPL_DEFECT_FRAMES)
	) u_defect_filter (
		.clock     (clock),
		.reset     (reset),
		.clk_en    (clk_en),
		.strobe    (rx_frame_valid),
		.value     (rx_code_map),
		.acc_value (acc_code),
		.acc_valid (acc_code_v)
	);

	// ==================================================
	// Remote error counters
	logic [31:0] tick_count;

	wpl_err_counters u_counters (
		.clock         (clock),
		.reset         (reset),
		.clk_en        (clk_en),
		.frame_strobe  (rx_frame_valid),
		.rei           (rx_rei),
		.block_mode    (cfg_r.remote_err_block_mode),
		.tick          (stats_snapshot_tick),
		.wrap_count    (remote_err_wrap_counter),
		.tick_count    (tick_count),
		.tick_snapshot (remote_err_tick_counter)
	);

	// ==================================================
	// Status, pending flags and interrupt routing
	wpl_stat_t             stat_r, stat_nxt;
	logic                  irq_a_r, irq_a_nxt, irq_b_r, irq_b_nxt;
	logic                  uneq_now, mism_now, fdef_now, fpay_now, fsrv_now, funeq_now;
	logic [WPL_NUM_EV-1:0] set_ev, route_a, route_b;

	always_comb begin
		uneq_now  = acc_label_v && acc_label == WPL_LABEL_UNEQ;
		mism_now  = acc_label_v && acc_label != WPL_LABEL_UNEQ &&
			acc_label != cfg_r.expected_signal_label;
		fdef_now  = acc_code_v && acc_code != WPL_CODE_CLEAR1 && acc_code != WPL_CODE_NONE;
		fpay_now  = acc_code_v && acc_code == WPL_CODE_PAYLOAD;
		fsrv_now  = acc_code_v && acc_code == WPL_CODE_SERVER;
		funeq_now = acc_code_v && acc_code == WPL_CODE_CONN;

		set_ev                  = '0;
		set_ev[WPL_EV_UNEQ]     = uneq_now && !stat_r.unequipped_live;
		set_ev[WPL_EV_MISMATCH] = mism_now && !(stat_r.accepted_label == acc_label &&
			stat_r.label_mismatch_latched);
		// Nonzero conditions keep setting while they persist
		set_ev[WPL_EV_WRAP_NZ]  = remote_err_wrap_counter != 16'h0000;
		set_ev[WPL_EV_TICK_NZ]  = tick_count != 32'h0;
		set_ev[WPL_EV_FAR_DEF]  = fdef_now && !stat_r.far_defect_live;
		set_ev[WPL_EV_FAR_PAY]  = fpay_now;
		set_ev[WPL_EV_FAR_SRV]  = fsrv_now;
		set_ev[WPL_EV_FAR_UNEQ] = funeq_now && !stat_r.far_unequipped_live;

		stat_nxt                           = stat_r;
		stat_nxt.accepted_label            = acc_label;
		stat_nxt.unequipped_live           = uneq_now;
		stat_nxt.remote_err_nonzero_live   = set_ev[WPL_EV_WRAP_NZ];
		stat_nxt.tick_counter_nonzero_live = set_ev[WPL_EV_TICK_NZ];
		stat_nxt.far_defect_live           = fdef_now;
		stat_nxt.far_unequipped_live       = funeq_now;
		// Read clears first, so a same-cycle set survives
		if (pending_read) begin
			stat_nxt.pending                    = '0;
			stat_nxt.label_mismatch_latched     = 1'b0;
			stat_nxt.far_payload_defect_latched = 1'b0;
			stat_nxt.far_server_defect_latched  = 1'b0;
		end
		stat_nxt.pending = stat_nxt.pending | set_ev;
		stat_nxt.label_mismatch_latched     = stat_nxt.label_mismatch_latched | mism_now;
		stat_nxt.far_payload_defect_latched = stat_nxt.far_payload_defect_latched | fpay_now;
		stat_nxt.far_server_defect_latched  = stat_nxt.far_server_defect_latched | fsrv_now;

		// Far unequipped shares the far defect mask
		route_a = {cfg_r.mask_a[WPL_EV_FAR_DEF], cfg_r.mask_a};
		route_b = {cfg_r.mask_b[WPL_EV_FAR_DEF], cfg_r.mask_b};
		irq_a_nxt = |(stat_nxt.pending & route_a);
		irq_b_nxt = |(stat_nxt.pending & route_b);
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			stat_r  <= WPL_STAT_RST;
			irq_a_r <= 1'b0;
			irq_b_r <= 1'b0;
		end else if (clk_en) begin
			stat_r  <= stat_nxt;
			irq_a_r <= irq_a_nxt;
			irq_b_r <= irq_b_nxt;
		end
	end

	assign status    = stat_r;
	assign irq_out_a = irq_a_r;
	assign irq_out_b = irq_b_r;

	// ==================================================
	// Transmit label and status octets
	logic [3:0] rei_hold_r, rei_hold_nxt;
	logic       rei_hold_v_r, rei_hold_v_nxt;
	logic [7:0] tx_label_r, tx_label_nxt, tx_status_r, tx_status_nxt;
	logic       tx_valid_r, tx_valid_nxt;
	logic [3:0] tx_rei;
	logic [2:0] tx_code;

	always_comb begin
		// Only the newest count is kept; an untaken older one is dropped
		rei_hold_nxt   = rei_hold_r;
		rei_hold_v_nxt = rei_hold_v_r;
		tx_rei         = rei_hold_v_r ? rei_hold_r : 4'h0;
		if (tx_frame_start) begin
			rei_hold_v_nxt = 1'b0;
		end
		if (near_b3_valid) begin
			rei_hold_nxt   = near_b3_count;
			rei_hold_v_nxt = 1'b1;
		end

		if (cfg_r.tx_enhanced_defect_sel) begin
			if (near_server_defect) begin
				tx_code = WPL_CODE_SERVER;
			end else if (stat_r.unequipped_live || near_connectivity_force) begin
				tx_code = WPL_CODE_CONN;
			end else if (stat_r.label_mismatch_latched && mism_now || near_payload_defect) begin
				tx_code = WPL_CODE_PAYLOAD;
			end else begin
				tx_code = WPL_CODE_NONE;
			end
		end else begin
			// Bits 6 and 7 forced to zero
			tx_code = near_server_defect ? WPL_CODE_RDI1 : WPL_CODE_CLEAR1;
		end

		tx_valid_nxt  = tx_frame_start;
		tx_label_nxt  = tx_label_r;
		tx_status_nxt = tx_status_r;
		if (tx_frame_start) begin
			tx_label_nxt  = cfg_r.tx_signal_label;
			tx_status_nxt = {tx_rei, tx_code, 1'b0};
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			rei_hold_r   <= '0;
			rei_hold_v_r <= 1'b0;
			tx_label_r   <= WPL_LABEL_RST;
			tx_status_r  <= '0;
			tx_valid_r   <= 1'b0;
		end else if (clk_en) begin
			rei_hold_r   <= rei_hold_nxt;
			rei_hold_v_r <= rei_hold_v_nxt;
			tx_label_r   <= tx_label_nxt;
			tx_status_r  <= tx_status_nxt;
			tx_valid_r   <= tx_valid_nxt;
		end
	end

	assign tx_octets_valid = tx_valid_r;
	assign tx_label_octet  = tx_label_r;
	assign tx_status_octet = tx_status_r;

	// ==================================================
	// Checks
	property p_tx_label;
		@(posedge clock) disable iff (reset)
		(clk_en && tx_frame_start) |=> (tx_octets_valid && tx_label_octet == $past(cfg_r.tx_signal_label));
	endproperty
	a_tx_label: assert property (p_tx_label) else $error("label octet not sent");

	property p_uneq_pend;
		@(posedge clock) disable iff (reset)
		(clk_en && acc_label_v && acc_label == WPL_LABEL_UNEQ && !status.unequipped_live) |=>
			(status.unequipped_live && status.pending[WPL_EV_UNEQ]);
	endproperty
	a_uneq_pend: assert property (p_uneq_pend) else $error("unequipped not flagged");

	property p_onebit_zero;
		@(posedge clock) disable iff (reset)
		(clk_en && tx_frame_start && !cfg_r.tx_enhanced_defect_sel) |=>
			(tx_status_octet[2:0] == 3'h0);
	endproperty
	a_onebit_zero: assert property (p_onebit_zero) else $error("one-bit spare bits set");

	property p_server_first;
		@(posedge clock) disable iff (reset)
		(clk_en && tx_frame_start && cfg_r.tx_enhanced_defect_sel && near_server_defect) |=>
			(tx_status_octet[WPL_CODE_MSB:WPL_CODE_LSB] == WPL_CODE_SERVER);
	endproperty
	a_server_first: assert property (p_server_first) else $error("server code lost priority");

	property p_rei_zero;
		@(posedge clock) disable iff (reset)
		(clk_en && tx_frame_start && !rei_hold_v_r) |=>
			(tx_status_octet[WPL_REI_MSB:WPL_REI_LSB] == 4'h0);
	endproperty
	a_rei_zero: assert property (p_rei_zero) else $error("count sent without source");

	property p_irq_route;
		@(posedge clock) disable iff (reset)
		($past(clk_en) && $stable(cfg_r) &&
			|(status.pending & {cfg_r.mask_a[WPL_EV_FAR_DEF], cfg_r.mask_a})) |-> irq_out_a;
	endproperty
	a_irq_route: assert property (p_irq_route) else $error("masked pending did not interrupt");
endmodule : wpl_path_monitor
`default_nettype wire

// File: tb/wpl_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module wpl_far_end import wpl_pkg::*; (
	// Clock
	input  wire logic       clock,
	// Frames towards the block
	output logic            rx_frame_valid,
	output logic      [7:0] rx_label_octet,
	output logic      [7:0] rx_status_octet,
	// Frames from the block
	input  wire logic       tx_octets_valid,
	input  wire logic [7:0] tx_label_octet,
	input  wire logic [7:0] tx_status_octet
);
	// ==================================================
	// Received octets, as the far terminal sees them
	logic [7:0] seen_label;
	logic [7:0] seen_status;

	initial begin
		rx_frame_valid  = 1'b0;
		rx_label_octet  = 8'hFF;
		rx_status_octet = 8'hFF;
	end

	// Octets inverted between frames, so stale values never pass as good
	task automatic send(input logic [7:0] lbl, input logic [7:0] sts, input int n);
		repeat (n) begin
			@(posedge clock);
			rx_frame_valid  <= 1'b1;
			rx_label_octet  <= lbl;
			rx_status_octet <= sts;
			@(posedge clock);
			rx_frame_valid  <= 1'b0;
			rx_label_octet  <= ~lbl;
			rx_status_octet <= ~sts;
		end
	endtask : send

	always @(posedge clock) begin
		if (tx_octets_valid) begin
			seen_label  <= tx_label_octet;
			seen_status <= tx_status_octet;
		end
	end
endmodule : wpl_far_end
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import wpl_pkg::*;;
	// ==================================================
	// Stimulus and observation
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic        ce = 1'b1;
	logic        cfg_load = 1'b0;
	logic        rd = 1'b0;
	logic        tick = 1'b0;
	logic        srv = 1'b0;
	logic        pay = 1'b0;
	logic        conn = 1'b0;
	logic        b3v = 1'b0;
	logic [3:0]  b3c = 4'h0;
	logic        txs = 1'b0;
	wpl_cfg_t    cfg_in = WPL_CFG_RST;
	wpl_cfg_t    cfg_v;
	wpl_cfg_t    cfg_out;
	wpl_stat_t   status;
	logic        rxv;
	logic [7:0]  rxl;
	logic [7:0]  rxs;
	logic        txv;
	logic [7:0]  txl;
	logic [7:0]  txo;
	logic [15:0] wrap;
	logic [31:0] tick_cnt;
	logic        irq_a;
	logic        irq_b;
	int          err_total = 0;
	int          n_checks = 0;
	logic [2:0]  codes [3] = '{WPL_CODE_PAYLOAD, WPL_CODE_SERVER, WPL_CODE_CONN};

	initial forever #25 clock = ~clock;

	wpl_path_monitor uut (
		.clock(clock), .reset(reset), .clk_en(ce), .cfg_load(cfg_load), .cfg_in(cfg_in),
		.pending_read(rd), .stats_snapshot_tick(tick), .near_server_defect(srv),
		.near_payload_defect(pay), .near_connectivity_force(conn), .near_b3_valid(b3v),
		.near_b3_count(b3c), .tx_frame_start(txs), .tx_octets_valid(txv),
		.tx_label_octet(txl), .tx_status_octet(txo), .rx_frame_valid(rxv),
		.rx_label_octet(rxl), .rx_status_octet(rxs), .cfg_out(cfg_out), .status(status),
		.remote_err_wrap_counter(wrap), .remote_err_tick_counter(tick_cnt),
		.irq_out_a(irq_a), .irq_out_b(irq_b)
	);

	wpl_far_end far (
		.clock(clock), .rx_frame_valid(rxv), .rx_label_octet(rxl), .rx_status_octet(rxs),
		.tx_octets_valid(txv), .tx_label_octet(txl), .tx_status_octet(txo)
	);

	// ==================================================
	// Access tasks
	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : chk

	task automatic w(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : w

	task automatic load(input wpl_cfg_t c);
		@(posedge clock);
		cfg_in   <= c;
		cfg_load <= 1'b1;
		@(posedge clock);
		cfg_load <= 1'b0;
	endtask : load

	// Kind 0 reads the pending flags, kind 1 is a snapshot tick
	task automatic strobe(input int kind);
		@(posedge clock);
		rd   <= (kind == 0);
		tick <= (kind == 1);
		@(posedge clock);
		rd   <= 1'b0;
		tick <= 1'b0;
	endtask : strobe

	task automatic b3(input logic [3:0] c);
		@(posedge clock);
		b3v <= 1'b1;
		b3c <= c;
		@(posedge clock);
		b3v <= 1'b0;
	endtask : b3

	// Near conditions {server, payload, connectivity} sampled with the frame
	task automatic txf(input logic [2:0] cond, input logic [7:0] exp);
		@(posedge clock);
		{srv, pay, conn} <= cond;
		txs <= 1'b1;
		@(posedge clock);
		txs <= 1'b0;
		w(3);
		chk(far.seen_status, exp, "tx status");
		chk(far.seen_label, cfg_v.tx_signal_label, "tx label");
	endtask : txf

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	// ==================================================
	// Tests
	initial begin
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		w(1);
		chk(cfg_out, WPL_CFG_RST, "config reset");
		cfg_v = WPL_CFG_RST;
		txf(3'b000, 8'h02);
		b3(4'h3);
		txf(3'b000, 8'h32);
		txf(3'b000, 8'h02);
		b3(4'h2);
		b3(4'h5);
		txf(3'b000, 8'h52);
		txf(3'b010, 8'h04);
		txf(3'b011, 8'h0C);
		txf(3'b111, 8'h0A);
		cfg_v.tx_enhanced_defect_sel = 1'b0;
		cfg_v.tx_signal_label = 8'hC5;
		load(cfg_v);
		txf(3'b100, 8'h08);
		txf(3'b011, 8'h00);
		$display("test transmit done");

		cfg_v.tx_enhanced_defect_sel = 1'b1;
		cfg_v.mask_a = 7'h01;
		cfg_v.mask_b = 7'h02;
		load(cfg_v);
		far.send(8'h00, 8'h02, 4);
		w(3);
		chk(status.unequipped_live, 1'b0, "label taken early");
		far.send(8'h00, 8'h02, 1);
		w(3);
		chk({status.unequipped_live, status.pending[0], irq_a, irq_b}, 4'hE, "unequipped");
		strobe(0);
		w(2);
		chk({status.pending[0], irq_a}, 2'b00, "read clears");
		far.send(8'h55, 8'h02, 5);
		w(3);
		chk({status.label_mismatch_latched, status.pending[1], irq_b, status.unequipped_live},
			4'hE, "mismatch");
		chk(status.accepted_label, 8'h55, "accepted label");
		txf(3'b000, 8'h04);
		$display("test label done");

		far.send(8'h55, 8'h32, 2);
		w(3);
		chk(wrap, 16'h0002, "wrap count");
		strobe(1);
		w(2);
		chk(tick_cnt, 32'h6, "tick snapshot");
		chk({status.tick_counter_nonzero_live, status.pending[3]}, 2'b01, "tick flag");
		strobe(0);
		w(3);
		chk({status.pending[3:2], status.remote_err_nonzero_live}, 3'b011, "after read");
		cfg_v.remote_err_block_mode = 1'b1;
		load(cfg_v);
		far.send(8'h55, 8'h82, 2);
		far.send(8'h55, 8'h92, 1);
		strobe(1);
		w(2);
		chk(tick_cnt, 32'h2, "block mode");
		chk(wrap, 16'h0004, "wrap count");
		// Frames while the enable is low must leave every count alone
		@(posedge clock);
		ce <= 1'b0;
		far.send(8'h55, 8'h32, 2);
		@(posedge clock);
		ce <= 1'b1;
		w(2);
		chk({wrap, tick_cnt}, {16'h0004, 32'h2}, "frozen");
		$display("test counters done");

		for (int i = 0; i < 3; i++) begin
			strobe(0);
			far.send(8'h55, {4'h0, codes[i], 1'b1}, 9);
			w(3);
			chk(status.far_defect_live, 1'b0, "nine frames");
			far.send(8'h55, {4'h0, codes[i], 1'b1}, 1);
			w(3);
			chk({status.far_defect_live, status.far_payload_defect_latched,
				status.far_server_defect_latched, status.far_unequipped_live, status.pending[7:5]},
				{1'b1, 3'b100 >> i, 3'b001 << i}, "defect code");
			far.send(8'h55, 8'h03, 10);
			w(3);
			chk(status.far_defect_live, 1'b0, "defect ends");
		end
		cfg_v.rx_enhanced_defect_sel = 1'b0;
		load(cfg_v);
		strobe(0);
		far.send(8'h55, 8'h09, 9);
		w(3);
		chk(status.far_defect_live, 1'b0, "one-bit nine");
		far.send(8'h55, 8'h0F, 1);
		w(3);
		chk({status.far_defect_live, status.pending[4]}, 2'b11, "one-bit defect");
		far.send(8'h55, 8'h06, 10);
		w(3);
		chk(status.far_defect_live, 1'b0, "one-bit clear");
		$display("test defects done");
		results();
	end

	// Whole run needs some 350 cycles
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		results();
	end
endmodule : tb
`default_nettype wire
